// File: logic/ufc_channel_ctl.sv
// Serial channel control: FIFO control, framing, modem control, AXI4-Lite
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ufc_channel_ctl
    import ufc_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // FIFO events from the data path
    input  wire logic        rx_push_i,
    input  wire logic        rx_pop_i,
    input  wire logic        tx_push_i,
    input  wire logic        tx_pop_i,
    output logic             rx_push_ready_o,
    output logic             tx_push_ready_o,
    // Data path control
    output ufc_frame_t       frame_o,
    output logic             fifo_en_o,
    output logic             dma_mode_o,
    output logic             baud_tick_o,
    output logic [15:0]      divisor_o,
    output logic             xon_any_en_o,
    output logic             xoff_resend_en_o,
    output logic [7:0]       xoff_resend_count_o,
    output logic             rx_data_irq_o,
    output logic             tx_trig_reached_o,
    // Parity generation and check
    input  wire logic [7:0]  tx_char_i,
    output logic             tx_parity_o,
    input  wire logic        rx_check_i,
    input  wire logic [7:0]  rx_char_i,
    input  wire logic        rx_parity_i,
    output logic             rx_parity_err_o,
    // Serial line
    input  wire logic        tx_shift_i,
    output logic             rx_shift_o,
    output logic             txd_o,
    input  wire logic        rxd_i,
    // Modem lines
    output logic             rts_n_o,
    output logic             dtr_n_o,
    input  wire logic        cts_n_i,
    input  wire logic        dsr_n_i,
    input  wire logic        ri_n_i,
    input  wire logic        dcd_n_i,
    output logic [3:0]       modem_status_hi_o
);

    ufc_state_t st;            // Registered state
    ufc_state_t next_st;       // Next state
    logic       loop_on;       // Internal loopback
    logic       dlab;          // Divisor latch open
    logic [6:0] rx_trig;       // Receive threshold
    logic [6:0] tx_trig;       // Effective transmit threshold
    logic [6:0] cap;           // Current FIFO capacity
    logic       line_out;      // Transmit line after break
    logic       aw_fire;       // Write address taken
    logic       w_fire;        // Write data taken
    logic       ar_fire;       // Read address taken

    // Parity bit for a character under the current framing
    function automatic logic par_of(input logic [7:0] c,
                                    input logic [7:0] lf);
        logic [7:0] m;
        m = c & (8'hff >> (2'd3 - lf[LF_WLEN +: 2]));
        unique case (lf[LF_PAR +: 3])
            3'b001:  par_of = ~^m;          // Odd
            3'b011:  par_of = ^m;           // Even
            3'b101:  par_of = 1'b1;         // Stick 1
            3'b111:  par_of = 1'b0;         // Stick 0
            default: par_of = 1'b0;         // No parity
        endcase
    endfunction

    // Decoded controls
    always_comb begin
        loop_on = st.modem_ctl[MC_LOOP];
        dlab    = st.line_fmt[LF_DLAB];
        cap     = st.fifo_ctl[FC_EN] ? FIFO_DEPTH : HOLD_DEPTH;
        // Receive threshold lookup
        unique case (st.fifo_ctl[FC_RX_TRIG +: 2])
            2'd0: rx_trig = RX_TRIG_0;
            2'd1: rx_trig = RX_TRIG_1;
            2'd2: rx_trig = RX_TRIG_2;
            2'd3: rx_trig = RX_TRIG_3;
        endcase
        // Transmit field applies only with the enhanced enable
        unique case (st.enh_ctl[EF_ENH] ? st.fifo_ctl[FC_TX_TRIG +: 2]
                                        : 2'd0)
            2'd0: tx_trig = TX_TRIG_0;
            2'd1: tx_trig = TX_TRIG_1;
            2'd2: tx_trig = TX_TRIG_2;
            2'd3: tx_trig = TX_TRIG_3;
        endcase
    end

    // Handshake terms
    assign aw_fire = s_axi_awvalid_i && s_axi_awready_o;
    assign w_fire  = s_axi_wvalid_i && s_axi_wready_o;
    assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;

    // Next-state logic: bus slave, registers, FIFO levels, prescaler
    always_comb begin
        next_st = st;
        // Pending FIFO resets act now and drop their bits
        next_st.fifo_ctl[FC_TX_RST] = 1'b0;
        next_st.fifo_ctl[FC_RX_RST] = 1'b0;
        // Receive level: reset wins over events
        if (st.fifo_ctl[FC_RX_RST]) begin
            next_st.rx_lvl = '0;
        end else if (rx_push_i && rx_push_ready_o && !rx_pop_i) begin
            next_st.rx_lvl = st.rx_lvl + 7'd1;
        end else if (rx_pop_i && !rx_push_i && st.rx_lvl != '0) begin
            next_st.rx_lvl = st.rx_lvl - 7'd1;
        end
        // Transmit level: reset wins over events
        if (st.fifo_ctl[FC_TX_RST]) begin
            next_st.tx_lvl = '0;
        end else if (tx_push_i && tx_push_ready_o && !tx_pop_i) begin
            next_st.tx_lvl = st.tx_lvl + 7'd1;
        end else if (tx_pop_i && !tx_push_i && st.tx_lvl != '0) begin
            next_st.tx_lvl = st.tx_lvl - 7'd1;
        end
        // Prescaler counts every rising clock edge
        next_st.presc = st.presc + 2'd1;
        // Receive parity check result
        if (rx_check_i) begin
            next_st.par_err = st.line_fmt[LF_PAR] &&
                (rx_parity_i != par_of(rx_char_i, st.line_fmt));
        end
        // Capture write address and data in either order
        if (aw_fire) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr_i;
        end
        if (w_fire) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata_i;
            next_st.w_strb = s_axi_wstrb_i;
        end
        // Perform the write once both halves are held
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = RESP_OKAY;
            unique case (st.aw_addr)
                // FIFO control; reset bits latch for one cycle
                OFF_FIFO_CTL: if (st.w_strb[0]) begin
                    next_st.fifo_ctl[FC_RX_TRIG +: 2] =
                        st.w_data[FC_RX_TRIG +: 2];
                    if (st.enh_ctl[EF_ENH]) begin
                        next_st.fifo_ctl[FC_TX_TRIG +: 2] =
                            st.w_data[FC_TX_TRIG +: 2];
                    end
                    next_st.fifo_ctl[FC_DMA] = st.w_data[FC_DMA];
                    next_st.fifo_ctl[FC_TX_RST] =
                        st.w_data[FC_TX_RST];
                    next_st.fifo_ctl[FC_RX_RST] =
                        st.w_data[FC_RX_RST];
                    next_st.fifo_ctl[FC_EN] = st.w_data[FC_EN];
                end
                OFF_LINE_FMT: if (st.w_strb[0]) begin
                    next_st.line_fmt = st.w_data[7:0];
                end
                OFF_MODEM_CTL: if (st.w_strb[0]) begin
                    next_st.modem_ctl = st.w_data[7:0];
                end
                OFF_ENH_CTL: if (st.w_strb[0]) begin
                    next_st.enh_ctl = st.w_data[7:0];
                end
                // Divisor only while the latch is open
                OFF_DIVISOR: begin
                    if (!dlab) begin
                        next_st.bresp = RESP_SLVERR;
                    end else begin
                        if (st.w_strb[0]) begin
                            next_st.divisor[7:0] = st.w_data[7:0];
                        end
                        if (st.w_strb[1]) begin
                            next_st.divisor[15:8] = st.w_data[15:8];
                        end
                    end
                end
                // Page 2 only with latch closed and page bit set
                OFF_XOFF_CNT: begin
                    if (dlab || !st.modem_ctl[MC_PAGE]) begin
                        next_st.bresp = RESP_SLVERR;
                    end else if (st.w_strb[0]) begin
                        next_st.xoff_cnt = st.w_data[7:0];
                    end
                end
                // Status is read only; the rest is unmapped
                default: next_st.bresp = RESP_SLVERR;
            endcase
        end
        // Write response retires
        if (st.bvalid && s_axi_bready_i) begin
            next_st.bvalid = 1'b0;
        end
        // Read answer
        if (ar_fire) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = RESP_OKAY;
            next_st.rdata  = '0;
            unique case (s_axi_araddr_i)
                OFF_FIFO_CTL:  next_st.rdata[7:0] = st.fifo_ctl;
                OFF_LINE_FMT:  next_st.rdata[7:0] = st.line_fmt;
                OFF_MODEM_CTL: next_st.rdata[7:0] = st.modem_ctl;
                OFF_ENH_CTL:   next_st.rdata[7:0] = st.enh_ctl;
                OFF_STATUS:    next_st.rdata = {9'h000, st.tx_lvl,
                                   1'b0, st.rx_lvl, 4'h0,
                                   modem_status_hi_o};
                OFF_DIVISOR: begin
                    if (dlab) begin
                        next_st.rdata[15:0] = st.divisor;
                    end else begin
                        next_st.rresp = RESP_SLVERR;
                    end
                end
                OFF_XOFF_CNT: begin
                    if (!dlab && st.modem_ctl[MC_PAGE]) begin
                        next_st.rdata[7:0] = st.xoff_cnt;
                    end else begin
                        next_st.rresp = RESP_SLVERR;
                    end
                end
                default: next_st.rresp = RESP_SLVERR;
            endcase
        end else if (st.rvalid && s_axi_rready_i) begin
            next_st.rvalid = 1'b0;
        end
    end

    // State register
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st           <= '0;
            st.fifo_ctl  <= FIFO_CTL_RST;
            st.line_fmt  <= LINE_FMT_RST;
            st.modem_ctl <= MODEM_CTL_RST;
            st.enh_ctl   <= ENH_CTL_RST;
            st.xoff_cnt  <= XOFF_CNT_RST;
            st.divisor   <= DIVISOR_RST;
        end else begin
            st <= next_st;
        end
    end

    // Bus handshakes
    assign s_axi_awready_o = !st.aw_held && !st.bvalid;
    assign s_axi_wready_o  = !st.w_held && !st.bvalid;
    assign s_axi_arready_o = !st.rvalid;
    assign s_axi_bvalid_o  = st.bvalid;
    assign s_axi_bresp_o   = st.bresp;
    assign s_axi_rvalid_o  = st.rvalid;
    assign s_axi_rdata_o   = st.rdata;
    assign s_axi_rresp_o   = st.rresp;

    // FIFO space for the data path
    assign rx_push_ready_o = st.rx_lvl < cap;
    assign tx_push_ready_o = st.tx_lvl < cap;

    // Framing fields
    always_comb begin
        frame_o.data_bits   = 4'd5 + {2'b00, st.line_fmt[LF_WLEN +: 2]};
        if (!st.line_fmt[LF_STOP]) begin
            frame_o.stop_halves = 3'd2;
        end else if (st.line_fmt[LF_WLEN +: 2] == 2'd0) begin
            frame_o.stop_halves = 3'd3;
        end else begin
            frame_o.stop_halves = 3'd4;
        end
        frame_o.parity_en   = st.line_fmt[LF_PAR];
        frame_o.parity_mode = st.line_fmt[LF_PAR+1 +: 2];
        frame_o.break_en    = st.line_fmt[LF_BREAK];
    end

    // Control outputs
    assign fifo_en_o           = st.fifo_ctl[FC_EN];
    assign dma_mode_o          = st.fifo_ctl[FC_DMA];
    assign divisor_o           = st.divisor;
    assign xon_any_en_o        = st.modem_ctl[MC_XON_ANY];
    assign xoff_resend_en_o    = st.modem_ctl[MC_AUX1] &&
                                 st.modem_ctl[MC_PAGE];
    assign xoff_resend_count_o = st.xoff_cnt;
    assign baud_tick_o         = !st.modem_ctl[MC_PRESC] ||
                                 (st.presc == PRESC_LAST);
    assign tx_trig_reached_o   = st.tx_lvl <= tx_trig;
    // Interrupt gated by aux output two
    assign rx_data_irq_o = st.modem_ctl[MC_AUX2] &&
                           (st.rx_lvl >= rx_trig);
    assign tx_parity_o     = par_of(tx_char_i, st.line_fmt);
    assign rx_parity_err_o = st.par_err;

    // Serial line and loopback
    assign line_out   = tx_shift_i && !st.line_fmt[LF_BREAK];
    assign txd_o      = loop_on ? 1'b1 : line_out;
    assign rx_shift_o = loop_on ? line_out : rxd_i;
    assign rts_n_o    = !st.modem_ctl[MC_RTS];
    assign dtr_n_o    = !st.modem_ctl[MC_DTR];
    // Upper modem status: looped control bits or the pins
    assign modem_status_hi_o = loop_on ?
        {~st.modem_ctl[MC_AUX2], ~st.modem_ctl[MC_AUX1],
         ~st.modem_ctl[MC_DTR], ~st.modem_ctl[MC_RTS]} :
        {~dcd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i};

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    tx_trig_lock_a: assert property (
        (st.aw_held && st.w_held && !st.bvalid &&
         st.aw_addr == OFF_FIFO_CTL && !st.enh_ctl[EF_ENH])
        |=> $stable(st.fifo_ctl[FC_TX_TRIG +: 2]))
        else $error("tx trigger changed without enhanced enable");
    tx_fifo_clear_a: assert property (
        st.fifo_ctl[FC_TX_RST] |=>
        st.tx_lvl == '0 && !st.fifo_ctl[FC_TX_RST])
        else $error("tx fifo reset did not clear level");
    rx_fifo_clear_a: assert property (
        st.fifo_ctl[FC_RX_RST] |=>
        st.rx_lvl == '0 && !st.fifo_ctl[FC_RX_RST])
        else $error("rx fifo reset did not clear level");
    break_low_a: assert property (
        st.line_fmt[LF_BREAK] |-> (loop_on ? !rx_shift_o : !txd_o))
        else $error("break did not hold the line low");
    loop_idle_a: assert property (
        loop_on |-> txd_o && (rx_shift_o == line_out))
        else $error("loopback leaked onto the line");
    loop_status_a: assert property (
        loop_on |-> modem_status_hi_o == {~st.modem_ctl[MC_AUX2],
            ~st.modem_ctl[MC_AUX1], dtr_n_o, rts_n_o})
        else $error("looped modem status wrong");
    presc_gap_a: assert property (
        (baud_tick_o && st.modem_ctl[MC_PRESC])
        |=> (!baud_tick_o || !st.modem_ctl[MC_PRESC])[*3])
        else $error("prescaler ticked early");
    stick_parity_a: assert property (
        (st.line_fmt[LF_PAR +: 3] == 3'b101) |-> tx_parity_o)
        else $error("stick parity not forced high");
    rx_irq_level_a: assert property (
        rx_data_irq_o == (st.modem_ctl[MC_AUX2] && st.rx_lvl >=
            (st.fifo_ctl[FC_RX_TRIG+1] ? (st.fifo_ctl[FC_RX_TRIG] ?
             RX_TRIG_3 : RX_TRIG_2) : (st.fifo_ctl[FC_RX_TRIG] ?
             RX_TRIG_1 : RX_TRIG_0))))
        else $error("receive interrupt missing at trigger");

endmodule

`default_nettype wire

// File: logic/ufc_pkg.sv
// Shared constants and carrier types for the serial channel control block
package ufc_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OFF_FIFO_CTL = 8'h00;
    localparam logic [7:0] OFF_LINE_FMT = 8'h04;
    localparam logic [7:0] OFF_MODEM_CTL = 8'h08;
    localparam logic [7:0] OFF_ENH_CTL = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_DIVISOR = 8'h14;
    localparam logic [7:0] OFF_XOFF_CNT = 8'h18;

    // Reset values
    localparam logic [7:0] FIFO_CTL_RST = 8'h00;
    localparam logic [7:0] LINE_FMT_RST = 8'h00;
    localparam logic [7:0] MODEM_CTL_RST = 8'h00;
    localparam logic [7:0] ENH_CTL_RST = 8'h00;
    localparam logic [7:0] XOFF_CNT_RST = 8'h00;
    localparam logic [15:0] DIVISOR_RST = 16'h0001;

    // Field positions in fifo_control
    localparam int FC_RX_TRIG = 6;
    localparam int FC_TX_TRIG = 4;
    localparam int FC_DMA = 3;
    localparam int FC_TX_RST = 2;
    localparam int FC_RX_RST = 1;
    localparam int FC_EN = 0;
    // Field positions in line_format_control
    localparam int LF_DLAB = 7;
    localparam int LF_BREAK = 6;
    localparam int LF_PAR = 3;
    localparam int LF_STOP = 2;
    localparam int LF_WLEN = 0;
    // Field positions in modem_line_control
    localparam int MC_PRESC = 7;
    localparam int MC_PAGE = 6;
    localparam int MC_XON_ANY = 5;
    localparam int MC_LOOP = 4;
    localparam int MC_AUX2 = 3;
    localparam int MC_AUX1 = 2;
    localparam int MC_RTS = 1;
    localparam int MC_DTR = 0;
    // Enhanced-function enable in enhanced_feature_control
    localparam int EF_ENH = 4;

    // Trigger thresholds in characters
    localparam logic [6:0] RX_TRIG_0 = 7'd8;
    localparam logic [6:0] RX_TRIG_1 = 7'd16;
    localparam logic [6:0] RX_TRIG_2 = 7'd56;
    localparam logic [6:0] RX_TRIG_3 = 7'd60;
    localparam logic [6:0] TX_TRIG_0 = 7'd8;
    localparam logic [6:0] TX_TRIG_1 = 7'd16;
    localparam logic [6:0] TX_TRIG_2 = 7'd32;
    localparam logic [6:0] TX_TRIG_3 = 7'd56;
    // FIFO capacity with and without FIFO mode
    localparam logic [6:0] FIFO_DEPTH = 7'd64;
    localparam logic [6:0] HOLD_DEPTH = 7'd1;
    // Prescaler terminal count for divide by four
    localparam logic [1:0] PRESC_LAST = 2'd3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Character framing handed to the shifters
    typedef struct packed {
        logic [3:0] data_bits;   // 5 to 8
        logic [2:0] stop_halves; // Stop length in half bits
        logic       parity_en;   // Parity bit present
        logic [1:0] parity_mode; // Line format bits 5:4
        logic       break_en;    // Line held low
    } ufc_frame_t;

    // Whole state of the block
    typedef struct packed {
        logic [7:0]  fifo_ctl;
        logic [7:0]  line_fmt;
        logic [7:0]  modem_ctl;
        logic [7:0]  enh_ctl;
        logic [7:0]  xoff_cnt;
        logic [15:0] divisor;
        logic [6:0]  rx_lvl;
        logic [6:0]  tx_lvl;
        logic [1:0]  presc;
        logic        par_err;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ufc_state_t;

endpackage

// File: tb/ufc_modem_model.sv
// Modem-side peer: drives status lines and a restless receive line
`timescale 1ns/1ps
`default_nettype none
module ufc_modem_model (
    // Clock and asserted status pattern
    input  wire logic       mclk_i,
    input  wire logic [3:0] status_i,
    // Active-low line side
    output logic            cts_n_o,
    output logic            dsr_n_o,
    output logic            ri_n_o,
    output logic            dcd_n_o,
    output logic            rxd_o
);
    // Status lines are active low
    assign {dcd_n_o, ri_n_o, dsr_n_o, cts_n_o} = ~status_i;
    // Receive line flips every cycle so a leak into the loop shows
    initial rxd_o = 1'b1;
    always @(posedge mclk_i) rxd_o <= ~rxd_o;
endmodule
`default_nettype wire

// File: tb/tb.sv
// Testbench for the serial channel control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ufc_pkg::*;
    logic mclk_i = 0, reset_n_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
    logic s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0, e;
    logic rx_push_i = 0, rx_check_i = 0, rx_parity_i = 0, tx_shift_i = 0;
    logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, tx_char_i = 0, mc;
    logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
    logic [3:0] st = 0, modem_status_hi_o;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic s_axi_rvalid_o, rx_data_irq_o, tx_parity_o, rx_parity_err_o;
    logic rx_shift_o, txd_o, rts_n_o, dtr_n_o, xoff_resend_en_o;
    logic [1:0] s_axi_rresp_o, s_axi_bresp_o, bq[$];
    logic fifo_en_o, dma_mode_o, xon_any_en_o, baud_tick_o;
    logic [15:0] divisor_o;
    int n;
    ufc_frame_t frame_o;
    wire logic cts_n_i, dsr_n_i, ri_n_i, dcd_n_i, rxd_i;
    logic [33:0] q[$];
    int miscompares = 0, tests_run = 0;
    ufc_channel_ctl DUT (.mclk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i,
        .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
        .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .rx_push_i,
        .rx_pop_i(1'b0), .tx_push_i(rx_push_i), .tx_pop_i(1'b0),
        .rx_push_ready_o(), .tx_push_ready_o(), .frame_o, .fifo_en_o,
        .dma_mode_o, .baud_tick_o, .divisor_o, .xon_any_en_o, .xoff_resend_en_o,
        .xoff_resend_count_o(), .rx_data_irq_o, .tx_trig_reached_o(),
        .tx_char_i, .tx_parity_o, .rx_check_i, .rx_char_i(tx_char_i),
        .rx_parity_i, .rx_parity_err_o, .tx_shift_i, .rx_shift_o, .txd_o,
        .rxd_i, .rts_n_o, .dtr_n_o, .cts_n_i, .dsr_n_i, .ri_n_i, .dcd_n_i,
        .modem_status_hi_o);
    ufc_modem_model peer (.mclk_i, .status_i(st), .cts_n_o(cts_n_i),
        .dsr_n_o(dsr_n_i), .ri_n_o(ri_n_i), .dcd_n_o(dcd_n_i), .rxd_o(rxd_i));
    // Clock of 4 ns period
    always #2 mclk_i = ~mclk_i;
    // Compare and count
    task cmp(input string n, input logic [33:0] x, input logic [33:0] g);
        tests_run++;
        if (g !== x) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    // Verdict and end of run
    task print_verdict;
        if (miscompares == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Register write: both halves offered, each dropped when taken
    task wr(input logic [7:0] a, input logic [7:0] d,
            input logic [1:0] r = RESP_OKAY);
        bq.push_back(r);
        @(posedge mclk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {24'h0, d};
        s_axi_awvalid_i <= 1;
        s_axi_wvalid_i <= 1;
        s_axi_bready_i <= 1;
        do begin
            @(posedge mclk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 0;
        end while (!s_axi_bvalid_o);
        s_axi_bready_i <= 0;
    endtask
    // Register read: expected answer noted for the monitor
    task rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
        q.push_back({r, d});
        @(posedge mclk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1;
        s_axi_rready_i <= 1;
        do begin
            @(posedge mclk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 0;
        end while (!s_axi_rvalid_o);
        s_axi_rready_i <= 0;
    endtask
    // Monitor takes the oldest note at each read answer
    always @(posedge mclk_i) if (s_axi_rvalid_o && s_axi_rready_i)
        cmp("rd", q.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
    // Monitor takes the oldest write response note at each answer
    always @(posedge mclk_i) if (s_axi_bvalid_o && s_axi_bready_i)
        cmp("wr", bq.pop_front(), s_axi_bresp_o);
    // Watchdog
    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        print_verdict;
    end
    // Main sequence
    initial begin
        mc = 8'($urandom(32'hb124));
        repeat (5) @(posedge mclk_i);
        reset_n_i <= 1;
        rd(OFF_FIFO_CTL, RESP_OKAY, 8'h00);
        rd(OFF_LINE_FMT, RESP_OKAY, 8'h00);
        rd(OFF_MODEM_CTL, RESP_OKAY, 8'h00);
        rd(8'h1c, RESP_SLVERR, 8'h00);
        wr(OFF_FIFO_CTL, 8'h31);
        rd(OFF_FIFO_CTL, RESP_OKAY, 8'h01);
        wr(OFF_MODEM_CTL, 8'h08);
        rx_push_i <= 1;
        repeat (7) @(posedge mclk_i);
        @(negedge mclk_i) cmp("irq", 0, rx_data_irq_o);
        @(posedge mclk_i) rx_push_i <= 0;
        @(negedge mclk_i) cmp("irq", 1, rx_data_irq_o);
        wr(OFF_FIFO_CTL, 8'h03);
        @(negedge mclk_i) cmp("irq", 0, rx_data_irq_o);
        rd(OFF_FIFO_CTL, RESP_OKAY, 8'h01);
        rd(OFF_STATUS, RESP_OKAY, 32'h0008_0000);
        rd(OFF_XOFF_CNT, RESP_SLVERR, 8'h00);
        wr(OFF_ENH_CTL, 8'h10);
        wr(OFF_FIFO_CTL, 8'h3d);
        rd(OFF_FIFO_CTL, RESP_OKAY, 8'h39);
        rd(OFF_STATUS, RESP_OKAY, 32'h0000_0000);
        @(negedge mclk_i) cmp("dma", 1, dma_mode_o);
        cmp("fifo_en", 1, fifo_en_o);
        wr(OFF_DIVISOR, 8'h5a, RESP_SLVERR);
        wr(OFF_LINE_FMT, 8'h80);
        wr(OFF_DIVISOR, 8'h5a);
        rd(OFF_DIVISOR, RESP_OKAY, 8'h5a);
        @(negedge mclk_i) cmp("div", 16'h005a, divisor_o);
        @(posedge mclk_i) tx_char_i <= 8'($urandom);
        tx_shift_i <= 1;
        for (int i = 0; i < 4; i++) begin
            wr(OFF_LINE_FMT, 8'(8'h0b | (i << 4)));
            e = (i == 0) ? ~^tx_char_i : (i == 1) ? ^tx_char_i : (i == 2);
            rx_parity_i <= ~e;
            rx_check_i <= 1;
            @(posedge mclk_i) rx_check_i <= 0;
            @(negedge mclk_i) cmp("par", e, tx_parity_o);
            cmp("perr", 1, rx_parity_err_o);
        end
        for (int w = 0; w < 4; w++) begin
            wr(OFF_LINE_FMT, 8'(8'h44 | w));
            @(negedge mclk_i) cmp("bits", 5 + w, frame_o.data_bits);
            cmp("stop", (w == 0) ? 3 : 4, frame_o.stop_halves);
            cmp("txd", 0, txd_o);
        end
        wr(OFF_LINE_FMT, 8'h00);
        st <= 4'($urandom);
        mc = {4'he, 4'($urandom)};
        wr(OFF_MODEM_CTL, mc);
        @(negedge mclk_i) cmp("rts", !mc[1], rts_n_o);
        cmp("dtr", !mc[0], dtr_n_o);
        cmp("xoff", mc[2], xoff_resend_en_o);
        cmp("msr", st, modem_status_hi_o);
        cmp("xon", 1, xon_any_en_o);
        cmp("txd", 1, txd_o);
        cmp("rxd", rxd_i, rx_shift_o);
        n = 0;
        repeat (8) @(negedge mclk_i) n += baud_tick_o;
        cmp("tick", 2, n);
        wr(OFF_MODEM_CTL, mc | 8'h10);
        @(negedge mclk_i) cmp("msr", {~mc[3:2], ~mc[0], ~mc[1]},
            modem_status_hi_o);
        cmp("txd", 1, txd_o);
        cmp("loop", 1, rx_shift_o);
        @(posedge mclk_i) tx_shift_i <= 0;
        @(negedge mclk_i) cmp("loop", 0, rx_shift_o);
        cmp("txd", 1, txd_o);
        print_verdict;
    end
endmodule
`default_nettype wire
